// ---- verilog/sib_consts.vh ----
// constants for the interrupt status bank: offsets, bit positions, masks, timing
`ifndef SIB_CONSTS_VH
`define SIB_CONSTS_VH

// ==========================================================================
// register offsets on the serial register port
`define SIB_ADDR_W            7
`define SIB_ADDR_SUMMARY      7'h60
`define SIB_ADDR_SYSTEM       7'h61
`define SIB_ADDR_SUPPLY       7'h62
`define SIB_ADDR_TRANSCEIVER  7'h63
`define SIB_ADDR_BANK_A_WAKE  7'h64
`define SIB_ADDR_BANK_A_FAULT 7'h65

// ==========================================================================
// global summary bit positions
`define SIB_SUM_SYSTEM        0
`define SIB_SUM_SUPPLY        1
`define SIB_SUM_TRANSCEIVER   2
`define SIB_SUM_BANK_A_WAKE   3
`define SIB_SUM_BANK_A_FAULT  4
`define SIB_SUM_BANK_B_WAKE   5
`define SIB_SUM_BANK_B_FAULT  6

// ==========================================================================
// system register bit positions
`define SIB_SYS_WATCHDOG      0
`define SIB_SYS_SERIAL_FAIL   1
`define SIB_SYS_OVERTEMP      2
`define SIB_SYS_POWER_ON      4
`define SIB_SYS_OV_SHUTDOWN   5

// supply register bit positions
`define SIB_SUP_MAIN_UNDER    0
`define SIB_SUP_EXT_UNDER     1
`define SIB_SUP_EXT_OVER      2
`define SIB_SUP_BATT_UNDER    3
`define SIB_SUP_BATT_OVER     4
`define SIB_SUP_SWITCHER      5

// transceiver register bit positions
`define SIB_TRX_CAN_WAKE      0
`define SIB_TRX_CAN_FAULT     1
`define SIB_TRX_LIN1_WAKE     2
`define SIB_TRX_LIN2_WAKE     3
`define SIB_TRX_SILENCE       4
`define SIB_TRX_FRAME_ERR     5

// ==========================================================================
// implemented-bit masks, reset values and always-enabled flags
`define SIB_MASK_SYSTEM       8'h37
`define SIB_MASK_SUPPLY       8'h3F
`define SIB_MASK_TRX_DUAL     8'h3F
`define SIB_MASK_TRX_SINGLE   8'h37
`define SIB_MASK_BANK_FULL    8'hFF
`define SIB_MASK_NONE         8'h00
`define SIB_RESET_SYSTEM      8'h10
`define SIB_RESET_OTHER       8'h00
`define SIB_ALWAYS_ON_SYSTEM  8'h31

// ==========================================================================
// serial transfer lengths that are accepted
`define SIB_LEN_W             6
`define SIB_LEN_16            6'h10
`define SIB_LEN_24            6'h18
`define SIB_LEN_32            6'h20

// ==========================================================================
// timing: clock period and bus silence timeout
`define SIB_CLK_PERIOD_NS     8
`define SIB_SILENCE_US        1000
// 1000 us at 8 ns, sized to the counter so the parameter default keeps its width
`define SIB_SILENCE_CYCLES    24'h01E848
`define SIB_SILENCE_CNT_W     24

`endif

// ---- verilog/sib_flag_bank.v ----
// one eight-bit bank of sticky pending flags with write-one-to-clear
`timescale 1ns/1ps

module sib_flag_bank #(
  parameter [7:0] IMPL_MASK = 8'hFF,
  parameter [7:0] RESET_VAL = 8'h00
) (
  input  wire       clk,
  input  wire       reset_n,
  input  wire [7:0] set_in,
  input  wire [7:0] clear_in,
  output reg  [7:0] flags_reg
);

  // ========================================================================
  // flag update
  wire [7:0] flags_next;

  // set beats clear in the same cycle so no event is lost; absent bits stay 0
  assign flags_next = ((flags_reg & ~clear_in) | set_in) & IMPL_MASK;

  // flags hold until cleared by the host
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= RESET_VAL & IMPL_MASK;
    end else begin
      flags_reg <= flags_next;
    end
  end

endmodule

// ---- verilog/sib_int_bank.v ----
// interrupt status register bank: pending flags, summary, interrupt pin
//
// How it works
// - summary 60h read-only, bit 7 zero; bits 0-2 show system, supply, transceiver pending.
// - summary bits 3,4 show bank A wake/fault; bits 5,6 bank B wake/fault.
// - without I/O pins bank A absent; with partial networking bank B bits read zero.
// - system flags: overvoltage shutdown 5, power-on 4, overtemp 2, serial fail 1, watchdog 0.
// - overvoltage shutdown, power-on and watchdog flags always reach the interrupt pin.
// - supply bit 5 sets whenever the switcher state bit changes value.
// - supply flags: battery over 4, battery under 3, rail over 2, rail under 1, main 0.
// - transceiver bit 5 flags a selective wake frame detection error.
// - bus silence flag at bit 4 once CAN stays silent beyond the timeout.
// - second LIN wake flag bit 3 only in dual-LIN builds; first LIN at bit 2.
// - CAN fault flag at bit 1, CAN wake flag at bit 0.
// - bank A wake: pin k rising edge bit 2(k-1), falling edge bit 2k-1.
// - bank A fault: pin k open load bit 2(k-1), short bit 2k-1.
// - serial fail on illegal code, locked write, or length not 16, 24, 32.
// - watchdog overflow while its flag pends requests a device reset.
`timescale 1ns/1ps
`include "sib_consts.vh"

module sib_int_bank #(
  parameter                          HAS_HIGH_VOLTAGE_IO_PIN       = 1,
  parameter                          HAS_PN         = 0,
  parameter                          DUAL_LIN       = 1,
  parameter [`SIB_SILENCE_CNT_W-1:0] SILENCE_CYCLES = `SIB_SILENCE_CYCLES
) (
  input  wire                   clk,
  input  wire                   reset_n,
  // register port from the serial decoder
  input  wire [`SIB_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata,
  // serial transfer checks
  input  wire                   spi_frame_done,
  input  wire [`SIB_LEN_W-1:0]  spi_clk_count,
  input  wire                   spi_illegal_code,
  input  wire                   spi_locked_write,
  // system events
  input  wire                   overvoltage_shutdown_evt,
  input  wire                   power_on_evt,
  input  wire                   overtemp_warning_evt,
  input  wire                   watchdog_overflow,
  // supply events
  input  wire                   switcher_state_bit,
  input  wire                   battery_over_evt,
  input  wire                   battery_under_evt,
  input  wire                   external_rail_over_evt,
  input  wire                   external_rail_under_evt,
  input  wire                   main_regulator_under_evt,
  // transceiver events
  input  wire                   selective_wake_frame_error_evt,
  input  wire                   can_bus_active,
  input  wire                   first_lin_wake_evt,
  input  wire                   second_lin_wake_evt,
  input  wire                   can_fault_evt,
  input  wire                   can_wake_evt,
  // high-voltage I/O bank A events, one bit per pin
  input  wire [3:0]             io_rising_edge_evt,
  input  wire [3:0]             io_falling_edge_evt,
  input  wire [3:0]             io_open_load_evt,
  input  wire [3:0]             io_short_evt,
  // bank B state and enables, kept in another block
  input  wire                   bank_b_wake_pending,
  input  wire                   bank_b_fault_pending,
  input  wire                   bank_b_irq_pending,
  input  wire [7:0]             system_enable,
  input  wire [7:0]             supply_enable,
  input  wire [7:0]             transceiver_enable,
  input  wire [7:0]             bank_a_wake_enable,
  input  wire [7:0]             bank_a_fault_enable,
  // outputs
  output reg                    interrupt_out_low,
  output reg                    watchdog_reset_req
);

  // ========================================================================
  // variant masks
  localparam [7:0] TRX_MASK  = (DUAL_LIN != 0) ? `SIB_MASK_TRX_DUAL : `SIB_MASK_TRX_SINGLE;
  localparam [7:0] BANK_MASK = (HAS_HIGH_VOLTAGE_IO_PIN != 0) ? `SIB_MASK_BANK_FULL : `SIB_MASK_NONE;
  localparam       HAS_B     = (HAS_PN == 0) ? 1'b1 : 1'b0;

  wire [7:0] sys_flags;
  wire [7:0] sup_flags;
  wire [7:0] trx_flags;
  wire [7:0] wake_flags;
  wire [7:0] fault_flags;

  reg  [7:0] sys_set;
  reg  [7:0] sup_set;
  reg  [7:0] trx_set;
  wire [7:0] wake_set;
  wire [7:0] fault_set;

  // ========================================================================
  // write-one-to-clear decode; the summary at 60h ignores writes
  wire [7:0] sys_clr   = (reg_wr && reg_addr == `SIB_ADDR_SYSTEM) ? reg_wdata : 8'h00;
  wire [7:0] sup_clr   = (reg_wr && reg_addr == `SIB_ADDR_SUPPLY) ? reg_wdata : 8'h00;
  wire [7:0] trx_clr   = (reg_wr && reg_addr == `SIB_ADDR_TRANSCEIVER) ? reg_wdata : 8'h00;
  wire [7:0] wake_clr  = (reg_wr && reg_addr == `SIB_ADDR_BANK_A_WAKE) ? reg_wdata : 8'h00;
  wire [7:0] fault_clr = (reg_wr && reg_addr == `SIB_ADDR_BANK_A_FAULT) ? reg_wdata : 8'h00;

  // ========================================================================
  // serial transfer failure: bad length, illegal code or locked write
  wire len_ok = (spi_clk_count == `SIB_LEN_16) || (spi_clk_count == `SIB_LEN_24) ||
                (spi_clk_count == `SIB_LEN_32);
  wire spi_fail = (spi_frame_done && !len_ok) || spi_illegal_code ||
                  spi_locked_write;

  // ========================================================================
  // watchdog: a second overflow while the flag still pends asks for reset
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_reset_req <= 1'b0;
    end else begin
      watchdog_reset_req <= watchdog_overflow & sys_flags[`SIB_SYS_WATCHDOG];
    end
  end

  // ========================================================================
  // switcher state change detector; first sample after reset only primes it
  reg switcher_prev_reg;
  reg switcher_primed_reg;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      switcher_prev_reg   <= 1'b0;
      switcher_primed_reg <= 1'b0;
    end else begin
      switcher_prev_reg   <= switcher_state_bit;
      switcher_primed_reg <= 1'b1;
    end
  end
  wire switcher_change = switcher_primed_reg &
                         (switcher_prev_reg ^ switcher_state_bit);

  // ========================================================================
  // bus silence timer: counts quiet cycles, fires once per silent stretch
  reg [`SIB_SILENCE_CNT_W-1:0] silence_cnt_reg;
  reg                          silence_fired_reg;
  wire silence_evt = !can_bus_active && !silence_fired_reg &&
                     (silence_cnt_reg >= SILENCE_CYCLES);

  // activity restarts the count; the counter stops once the flag has fired
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      silence_cnt_reg   <= {`SIB_SILENCE_CNT_W{1'b0}};
      silence_fired_reg <= 1'b0;
    end else if (can_bus_active) begin
      silence_cnt_reg   <= {`SIB_SILENCE_CNT_W{1'b0}};
      silence_fired_reg <= 1'b0;
    end else if (silence_evt) begin
      silence_fired_reg <= 1'b1;
    end else if (!silence_fired_reg) begin
      silence_cnt_reg   <= silence_cnt_reg + 1'b1;
    end
  end

  // ========================================================================
  // set vectors for the fixed-layout banks
  always @* begin
    sys_set = 8'h00;
    sys_set[`SIB_SYS_OV_SHUTDOWN] = overvoltage_shutdown_evt;
    sys_set[`SIB_SYS_POWER_ON]    = power_on_evt;
    sys_set[`SIB_SYS_OVERTEMP]    = overtemp_warning_evt;
    sys_set[`SIB_SYS_SERIAL_FAIL] = spi_fail;
    sys_set[`SIB_SYS_WATCHDOG]    = watchdog_overflow;
  end

  always @* begin
    sup_set = 8'h00;
    sup_set[`SIB_SUP_SWITCHER]   = switcher_change;
    sup_set[`SIB_SUP_BATT_OVER]  = battery_over_evt;
    sup_set[`SIB_SUP_BATT_UNDER] = battery_under_evt;
    sup_set[`SIB_SUP_EXT_OVER]   = external_rail_over_evt;
    sup_set[`SIB_SUP_EXT_UNDER]  = external_rail_under_evt;
    sup_set[`SIB_SUP_MAIN_UNDER] = main_regulator_under_evt;
  end

  // lin2 bit is masked off by the bank in single-LIN builds
  always @* begin
    trx_set = 8'h00;
    trx_set[`SIB_TRX_FRAME_ERR] = selective_wake_frame_error_evt;
    trx_set[`SIB_TRX_SILENCE]   = silence_evt;
    trx_set[`SIB_TRX_LIN2_WAKE] = second_lin_wake_evt;
    trx_set[`SIB_TRX_LIN1_WAKE] = first_lin_wake_evt;
    trx_set[`SIB_TRX_CAN_FAULT] = can_fault_evt;
    trx_set[`SIB_TRX_CAN_WAKE]  = can_wake_evt;
  end

  // ========================================================================
  // bank A: two bits per pin, even bit first
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_pin
      assign wake_set[2*k]    = io_rising_edge_evt[k];
      assign wake_set[2*k+1]  = io_falling_edge_evt[k];
      assign fault_set[2*k]   = io_open_load_evt[k];
      assign fault_set[2*k+1] = io_short_evt[k];
    end
  endgenerate

  // ========================================================================
  // flag banks; power-on flag comes out of reset pending
  sib_flag_bank #(
    .IMPL_MASK (`SIB_MASK_SYSTEM),
    .RESET_VAL (`SIB_RESET_SYSTEM)
  ) u_sys (
    .clk       (clk),
    .reset_n   (reset_n),
    .set_in    (sys_set),
    .clear_in  (sys_clr),
    .flags_reg (sys_flags)
  );

  sib_flag_bank #(
    .IMPL_MASK (`SIB_MASK_SUPPLY),
    .RESET_VAL (`SIB_RESET_OTHER)
  ) u_sup (
    .clk       (clk),
    .reset_n   (reset_n),
    .set_in    (sup_set),
    .clear_in  (sup_clr),
    .flags_reg (sup_flags)
  );

  sib_flag_bank #(
    .IMPL_MASK (TRX_MASK),
    .RESET_VAL (`SIB_RESET_OTHER)
  ) u_trx (
    .clk       (clk),
    .reset_n   (reset_n),
    .set_in    (trx_set),
    .clear_in  (trx_clr),
    .flags_reg (trx_flags)
  );

  // absent banks are held at zero by their mask
  sib_flag_bank #(
    .IMPL_MASK (BANK_MASK),
    .RESET_VAL (`SIB_RESET_OTHER)
  ) u_wake (
    .clk       (clk),
    .reset_n   (reset_n),
    .set_in    (wake_set),
    .clear_in  (wake_clr),
    .flags_reg (wake_flags)
  );

  sib_flag_bank #(
    .IMPL_MASK (BANK_MASK),
    .RESET_VAL (`SIB_RESET_OTHER)
  ) u_fault (
    .clk       (clk),
    .reset_n   (reset_n),
    .set_in    (fault_set),
    .clear_in  (fault_clr),
    .flags_reg (fault_flags)
  );

  // ========================================================================
  // global summary, computed live from the banks
  reg [7:0] summary;
  always @* begin
    summary = 8'h00;
    summary[`SIB_SUM_SYSTEM]       = |sys_flags;
    summary[`SIB_SUM_SUPPLY]       = |sup_flags;
    summary[`SIB_SUM_TRANSCEIVER]  = |trx_flags;
    summary[`SIB_SUM_BANK_A_WAKE]  = |wake_flags;
    summary[`SIB_SUM_BANK_A_FAULT] = |fault_flags;
    summary[`SIB_SUM_BANK_B_WAKE]  = HAS_B & bank_b_wake_pending;
    summary[`SIB_SUM_BANK_B_FAULT] = HAS_B & bank_b_fault_pending;
  end

  // ========================================================================
  // read mux; unmapped addresses read zero, data valid the cycle after reg_rd
  reg [7:0] rdata_next;
  always @* begin
    case (reg_addr)
      `SIB_ADDR_SUMMARY:      rdata_next = summary;
      `SIB_ADDR_SYSTEM:       rdata_next = sys_flags;
      `SIB_ADDR_SUPPLY:       rdata_next = sup_flags;
      `SIB_ADDR_TRANSCEIVER:  rdata_next = trx_flags;
      `SIB_ADDR_BANK_A_WAKE:  rdata_next = wake_flags;
      `SIB_ADDR_BANK_A_FAULT: rdata_next = fault_flags;
      default:                rdata_next = 8'h00;
    endcase
  end

  // read data holds until the next read
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // ========================================================================
  // interrupt pin; always-enabled system flags bypass the enable inputs
  wire [7:0] sys_gate = system_enable | `SIB_ALWAYS_ON_SYSTEM;
  wire irq_any = |(sys_flags & sys_gate) | |(sup_flags & supply_enable) |
                 |(trx_flags & transceiver_enable) |
                 |(wake_flags & bank_a_wake_enable) |
                 |(fault_flags & bank_a_fault_enable) |
                 (HAS_B & bank_b_irq_pending);

  // registered so the pin never glitches on decode
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      interrupt_out_low <= 1'b1;
    end else begin
      interrupt_out_low <= ~irq_any;
    end
  end

endmodule

// ---- testbench/sib_int_bank_props.sv ----
// port checker for the interrupt status bank, bound into the design
`timescale 1ns/1ps
`include "sib_consts.vh"

module sib_int_bank_props (
  input wire                   clk,
  input wire                   reset_n,
  input wire [`SIB_ADDR_W-1:0] reg_addr,
  input wire                   reg_rd,
  input wire [7:0]             reg_rdata,
  input wire                   spi_frame_done,
  input wire [`SIB_LEN_W-1:0]  spi_clk_count,
  input wire                   overvoltage_shutdown_evt,
  input wire                   power_on_evt,
  input wire                   watchdog_overflow,
  input wire                   can_wake_evt,
  input wire [7:0]             transceiver_enable,
  input wire                   interrupt_out_low,
  input wire                   watchdog_reset_req
);
  // ==========================================================================
  // helpers
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // only three lengths are legal, all others must raise the serial fail flag
  wire len_bad = spi_clk_count != `SIB_LEN_16 && spi_clk_count != `SIB_LEN_24 &&
                 spi_clk_count != `SIB_LEN_32;
  wire rd_sum  = reg_rd && reg_addr == `SIB_ADDR_SUMMARY;
  wire rd_sys  = reg_rd && reg_addr == `SIB_ADDR_SYSTEM;
  wire rd_hole = reg_rd && (reg_addr < `SIB_ADDR_SUMMARY || reg_addr > `SIB_ADDR_BANK_A_FAULT);
  // ==========================================================================
  // assertions
  a_summary_top_zero: assert property (rd_sum |=> reg_rdata[7] == 1'b0)
    else $error("summary bit 7 read as one");
  a_system_reserved: assert property (rd_sys |=> reg_rdata[7:6] == 2'b00 && !reg_rdata[3])
    else $error("system reserved bits read as one");
  a_upper_reserved: assert property (reg_rd && (reg_addr == `SIB_ADDR_SUPPLY ||
    reg_addr == `SIB_ADDR_TRANSCEIVER) |=> reg_rdata[7:6] == 2'b00)
    else $error("supply or transceiver reserved bits read as one");
  a_unmapped_zero: assert property (rd_hole |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_always_on_pin: assert property ((overvoltage_shutdown_evt || power_on_evt ||
    watchdog_overflow) |-> ##2 !interrupt_out_low)
    else $error("always enabled event did not pull the pin");
  a_poweron_pin: assert property ($rose(reset_n) |=> !interrupt_out_low)
    else $error("pin not low after reset release");
  a_can_wake_pin: assert property (can_wake_evt && transceiver_enable[0] ##1
    transceiver_enable[0] |-> ##1 !interrupt_out_low)
    else $error("enabled wake event did not pull the pin");
  a_serial_len: assert property (spi_frame_done && len_bad ##2 rd_sys |=>
    reg_rdata[`SIB_SYS_SERIAL_FAIL])
    else $error("bad transfer length not flagged");
  a_watchdog_cause: assert property (watchdog_reset_req |-> $past(watchdog_overflow))
    else $error("reset request without overflow");
  c_reset_req: cover property (watchdog_reset_req);
  c_pin_low_read: cover property (!interrupt_out_low && rd_sum);
  c_bad_length: cover property (spi_frame_done && len_bad);
endmodule

bind sib_int_bank sib_int_bank_props u_props (.clk, .reset_n, .reg_addr, .reg_rd, .reg_rdata,
  .spi_frame_done, .spi_clk_count, .overvoltage_shutdown_evt, .power_on_evt,
  .watchdog_overflow, .can_wake_evt, .transceiver_enable, .interrupt_out_low,
  .watchdog_reset_req);

// ---- testbench/sib_host_model.sv ----
// host side of the register port: strobed reads and write-one-to-clear writes
`timescale 1ns/1ps
`include "sib_consts.vh"

module sib_host_model (
  input  wire                   clk,
  input  wire [7:0]             reg_rdata,
  output reg  [`SIB_ADDR_W-1:0] reg_addr,
  output reg  [7:0]             reg_wdata,
  output reg                    reg_wr,
  output reg                    reg_rd
);
  // idle values: strobes low, address and data start at zero
  initial begin
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle write strobe; ones in the data clear flags
  task wr(input [`SIB_ADDR_W-1:0] a, input [7:0] v);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a; // released lines must not look valid
      reg_wdata = ~v;
    end
  endtask
  // one-cycle read strobe, data is registered on the taking edge
  task rd(input [`SIB_ADDR_W-1:0] a, output [7:0] v);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      v = reg_rdata;
      reg_addr = ~a;
    end
  endtask
endmodule

// ---- testbench/sib_int_bank_tb_top.sv ----
// self-checking bench for the interrupt status bank
`timescale 1ns/1ps
`include "sib_consts.vh"

module sib_int_bank_tb_top;
  // ==========================================================================
  // event table: bit position and register of events 0..13
  localparam [55:0] BIT_IDX = {4'h0, 4'h1, 4'h3, 4'h2, 4'h5, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
                               4'h0, 4'h2, 4'h4, 4'h5};
  localparam [27:0] REG_IDX = {10'h2AA, 10'h155, 8'h00};
  reg                   clk;
  reg                   reset_n;
  reg  [32:0]           ev;
  reg                   sw, can_act, bbw, bbf, bbi;
  reg  [5:0]            cnt;
  reg  [7:0]            en, a, m, d;
  integer               seed, errors, total_checks, i;
  wire [`SIB_ADDR_W-1:0] reg_addr;
  wire [7:0]            reg_wdata, reg_rdata;
  wire                  reg_wr, reg_rd, pin, wd_req;

  sib_host_model u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // short silence timeout keeps the run brief
  sib_int_bank #(.SILENCE_CYCLES(24'h000014)) u_dut (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .spi_frame_done(ev[32]), .spi_clk_count(cnt),
    .spi_illegal_code(ev[30]), .spi_locked_write(ev[31]),
    .overvoltage_shutdown_evt(ev[0]), .power_on_evt(ev[1]), .overtemp_warning_evt(ev[2]),
    .watchdog_overflow(ev[3]), .switcher_state_bit(sw), .battery_over_evt(ev[4]),
    .battery_under_evt(ev[5]), .external_rail_over_evt(ev[6]),
    .external_rail_under_evt(ev[7]), .main_regulator_under_evt(ev[8]),
    .selective_wake_frame_error_evt(ev[9]), .can_bus_active(can_act),
    .first_lin_wake_evt(ev[10]), .second_lin_wake_evt(ev[11]), .can_fault_evt(ev[12]),
    .can_wake_evt(ev[13]), .io_rising_edge_evt(ev[17:14]), .io_falling_edge_evt(ev[21:18]),
    .io_open_load_evt(ev[25:22]), .io_short_evt(ev[29:26]), .bank_b_wake_pending(bbw),
    .bank_b_fault_pending(bbf), .bank_b_irq_pending(bbi), .system_enable(en),
    .supply_enable(en), .transceiver_enable(en), .bank_a_wake_enable(en),
    .bank_a_fault_enable(en), .interrupt_out_low(pin), .watchdog_reset_req(wd_req));

  // ==========================================================================
  // helpers
  function [15:0] loc(input integer k);
    integer j;
    begin
      j = k - 14;
      if (k >= 30)
        loc = {1'b0, `SIB_ADDR_SYSTEM, 8'h02};
      else if (k >= 14)
        loc = {8'(8'h64 + j / 8), 8'(8'h01 << (2 * (j % 4) + (j / 4) % 2))};
      else
        loc = {8'(8'h61 + REG_IDX[k*2 +: 2]), 8'(8'h01 << BIT_IDX[k*4 +: 4])};
    end
  endfunction
  task chk(input string name, input [7:0] e, input [7:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("MISMATCH %0s expected %h seen %h", name, e, g);
      end
    end
  endtask
  task pulse(input integer k);
    begin
      @(negedge clk);
      ev[k] = 1'b1;
      @(negedge clk);
      ev[k] = 1'b0;
    end
  endtask
  task do_reset;
    begin
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
    end
  endtask
  task test_done;
    begin
      if (errors == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // ==========================================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #160000;
    errors = errors + 1;
    test_done;
  end

  // ==========================================================================
  // main sequence
  initial begin
    seed = 36052;
    errors = 0;
    total_checks = 0;
    {ev, sw, bbw, bbf, bbi} = 37'h0;
    can_act = 1'b1;
    cnt = `SIB_LEN_16;
    en = 8'hFF;
    reset_n = 1'b0;
    do_reset;
    u_host.rd(`SIB_ADDR_SYSTEM, d);
    chk("system reset", `SIB_RESET_SYSTEM, d);
    chk("pin after reset", 8'h00, {7'h00, pin});
    for (i = 2; i < 6; i = i + 1) begin
      u_host.rd(7'(8'h60 + i), d);
      chk("other reset", 8'h00, d);
    end
    u_host.rd(`SIB_ADDR_SUMMARY, d);
    chk("summary reset", 8'h01, d);
    for (i = 1; i < 6; i = i + 1)
      u_host.wr(7'(8'h60 + i), 8'hFF);
    // event lines 0..31 once each; random enables decide the pin except for always-on events 0, 1, 3
    for (i = 0; i < 32; i = i + 1) begin
      en = 8'($random(seed));
      {a, m} = loc(i);
      pulse(i);
      u_host.rd(a[6:0], d);
      chk("flag set", m, d);
      u_host.rd(`SIB_ADDR_SUMMARY, d);
      chk("summary", 8'(8'h01 << (a - 8'h61)), d);
      chk("pin", {7'h00, !(i == 0 || i == 1 || i == 3 || (en & m) != 8'h00)}, {7'h00, pin});
      u_host.wr(a[6:0], ~m);
      u_host.rd(a[6:0], d);
      chk("zero write", m, d);
      u_host.wr(a[6:0], m);
      u_host.rd(a[6:0], d);
      chk("cleared", 8'h00, d);
      chk("pin released", 8'h01, {7'h00, pin});
    end
    // transfer lengths: the three legal ones, then 0Fh and four random
    for (i = 0; i < 8; i = i + 1) begin
      cnt = (i == 0) ? `SIB_LEN_16 : (i == 1) ? `SIB_LEN_24 : (i == 2) ? `SIB_LEN_32 :
            (i == 3) ? 6'h0F : 6'($random(seed));
      pulse(32);
      u_host.rd(`SIB_ADDR_SYSTEM, d);
      chk("length", {6'h00, cnt != 6'h10 && cnt != 6'h18 && cnt != 6'h20, 1'b0}, d);
      u_host.wr(`SIB_ADDR_SYSTEM, 8'hFF);
    end
    sw = 1'b1;
    u_host.rd(`SIB_ADDR_SUPPLY, d);
    chk("switcher change", 8'h20, d);
    u_host.wr(`SIB_ADDR_SUPPLY, 8'hFF);
    u_host.rd(`SIB_ADDR_SUPPLY, d);
    chk("switcher steady", 8'h00, d);
    // silence just short of the timeout, then well past it
    can_act = 1'b0;
    repeat (18) @(negedge clk);
    can_act = 1'b1;
    u_host.rd(`SIB_ADDR_TRANSCEIVER, d);
    chk("short silence", 8'h00, d);
    can_act = 1'b0;
    repeat (25) @(negedge clk);
    can_act = 1'b1;
    u_host.rd(`SIB_ADDR_TRANSCEIVER, d);
    chk("long silence", 8'h10, d);
    u_host.wr(`SIB_ADDR_TRANSCEIVER, 8'hFF);
    {bbw, bbf, bbi, en} = {3'b111, 8'h00};
    u_host.rd(`SIB_ADDR_SUMMARY, d);
    chk("bank b summary", 8'h60, d);
    chk("bank b pin", 8'h00, {7'h00, pin});
    {bbw, bbf, bbi} = 3'b000;
    u_host.wr(`SIB_ADDR_SUMMARY, 8'hFF);
    u_host.wr(7'h66, 8'hFF);
    u_host.rd(7'h66, d);
    chk("unmapped", 8'h00, d);
    u_host.rd(`SIB_ADDR_SUMMARY, d);
    chk("summary idle", 8'h00, d);
    // second overflow while the flag still pends asks for a reset
    pulse(3);
    @(negedge clk);
    ev[3] = 1'b1;
    @(negedge clk);
    ev[3] = 1'b0;
    chk("reset request", 8'h01, {7'h00, wd_req});
    @(negedge clk);
    chk("request pulse", 8'h00, {7'h00, wd_req});
    u_host.wr(`SIB_ADDR_SYSTEM, 8'hFF);
    do_reset;
    u_host.rd(`SIB_ADDR_SYSTEM, d);
    chk("system rereset", `SIB_RESET_SYSTEM, d);
    test_done;
  end
endmodule
